// *** src/nsc_top.sv ***
// Nibble slice controller: register file, clocking, gating, calibration.
//
// Summary of operation
// - One controller drives seven slices in upper nibble, six in lower.
// - Sixty-four registers of sixteen bits hold delay and control values.
// - Runs self-calibration, makes slice clocks, drives rx and transmit_gating.
// - Paired controllers OR their read data and look like one interface.
// - Selected master clock drives calibration and serial-mode sampling.
// - Register interface runs on CLOCK, independent of the master clock sources.
// - Six-bit address selects the register accessed in the same cycle as the strobe.
// - Delay-ready output and status bit rise after fixed calibration ends.
`timescale 1ns/1ps
`default_nettype none
module nsc_top
   import nsc_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RESET_N,
   input wire logic CE,
   input wire logic PLL_CLK,
   input wire logic REF_CLK,
   input wire logic VT_TRACK_EN,
   input wire logic [6:0] DATA_IN,
   input wire logic STROBE_IN,
   input wire logic NIBBLE_SEL,
   input wire logic [5:0] ADDR,
   input wire logic [15:0] WR_DATA,
   input wire logic WR_EN,
   input wire logic RD_EN,
   output var logic [15:0] RD_DATA,
   output var logic DELAY_READY,
   output var logic VT_READY,
   output var logic RX_CLK,
   output var logic TX_CLK,
   output var logic RX_GATE,
   output var logic TX_GATE,
   output var logic [6:0] SLICE_ENABLE,
   output var logic IRQ
);
   // A generic entry is any address not taken by a dedicated register.
   function automatic logic is_generic(input logic [5:0] a);
      return a > NSC_OFS_SAMPLE;
   endfunction : is_generic

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and master clock tick selection.
   logic [9:0] sync1, sync2;
   logic [1:0] clk_prev;
   logic pll_rise, ref_rise, master_tick;
   logic [15:0] ctrl, next_ctrl;

   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         sync1 <= 10'h000;
         sync2 <= 10'h000;
         clk_prev <= 2'h0;
      end else if (CE) begin
         sync1 <= {STROBE_IN, DATA_IN, REF_CLK, PLL_CLK};
         sync2 <= sync1;
         clk_prev <= sync2[1:0];
      end
   end

   assign pll_rise = sync2[0] & ~clk_prev[0];
   assign ref_rise = sync2[1] & ~clk_prev[1];
   // Only the selected source may advance anything; rising edges of the idle one are ignored.
   assign master_tick = (ctrl[NSC_CTRL_SRC_BIT] == NSC_SRC_REF) ?
                        ref_rise : pll_rise;

   ////////////////////////////////////////////////////////////////////////
   // Calibration.
   logic cal_dly, cal_vt, cal_busy;

   nsc_cal u_cal (
      .clock(CLOCK),
      .reset_n(RESET_N),
      .ce(CE),
      .cal_en(ctrl[NSC_CTRL_CAL_EN_BIT]),
      .tick(master_tick),
      .vt_en(VT_TRACK_EN),
      .delay_ready(cal_dly),
      .vt_ready(cal_vt),
      .busy(cal_busy)
   );

   ////////////////////////////////////////////////////////////////////////
   // Register file.
   logic [15:0] mem [0:NSC_REG_COUNT-1];
   logic [15:0] next_mem [0:NSC_REG_COUNT-1];
   logic [2:0] int_stat, next_int_stat, int_mask, next_int_mask, events;
   logic [15:0] clk_div, next_clk_div, sample, next_sample;
   logic [15:0] rd_value, next_rd_data;
   logic wr_hit, rd_hit;

   assign wr_hit = WR_EN & NIBBLE_SEL;
   assign rd_hit = RD_EN & NIBBLE_SEL;
   // Events are edges of the ready flags against their registered copies.
   assign events = {VT_READY & ~cal_vt, cal_vt & ~VT_READY,
                    cal_dly & ~DELAY_READY};

   always_comb begin
      if (ADDR == NSC_OFS_CTRL) begin
         rd_value = ctrl;
      end else if (ADDR == NSC_OFS_STATUS) begin
         rd_value = 16'h0000;
         rd_value[NSC_ST_DLY_BIT] = cal_dly;
         rd_value[NSC_ST_VT_BIT] = cal_vt;
         rd_value[NSC_ST_BUSY_BIT] = cal_busy;
      end else if (ADDR == NSC_OFS_INT_STAT) begin
         rd_value = {13'h0000, int_stat};
      end else if (ADDR == NSC_OFS_INT_MASK) begin
         rd_value = {13'h0000, int_mask};
      end else if (ADDR == NSC_OFS_CLK_DIV) begin
         rd_value = clk_div;
      end else if (ADDR == NSC_OFS_SAMPLE) begin
         rd_value = sample;
      end else begin
         rd_value = mem[ADDR];
      end
   end

   always_comb begin
      next_mem = mem;
      next_ctrl = ctrl;
      next_int_mask = int_mask;
      next_clk_div = clk_div;
      next_sample = sample;
      // A new event wins over a same-cycle write-one-to-clear.
      next_int_stat = int_stat | events;
      if (wr_hit) begin
         if (ADDR == NSC_OFS_CTRL) begin
            next_ctrl = WR_DATA;
         end else if (ADDR == NSC_OFS_INT_STAT) begin
            next_int_stat = (int_stat & ~WR_DATA[2:0]) | events;
         end else if (ADDR == NSC_OFS_INT_MASK) begin
            next_int_mask = WR_DATA[2:0];
         end else if (ADDR == NSC_OFS_CLK_DIV) begin
            next_clk_div = WR_DATA;
         end else if (is_generic(ADDR)) begin
            next_mem[ADDR] = WR_DATA;
         end
      end
      if (master_tick && ctrl[NSC_CTRL_SERIAL_BIT]) begin
         next_sample = {8'h00, sync2[9:2]};
      end
      // Idle read data stays zero so two merged controllers OR cleanly.
      next_rd_data = rd_hit ? rd_value : 16'h0000;
   end

   // The register bus runs on CLOCK alone; the master sources never clock
   // it and only reach it as synchronised ticks.
   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         for (int i = 0; i < NSC_REG_COUNT; i++) begin
            mem[i] <= NSC_MEM_RESET;
         end
         ctrl <= NSC_CTRL_RESET;
         int_stat <= NSC_INT_RESET;
         int_mask <= NSC_INT_RESET;
         clk_div <= NSC_CLK_DIV_RESET;
         sample <= 16'h0000;
         RD_DATA <= 16'h0000;
      end else if (CE) begin
         mem <= next_mem;
         ctrl <= next_ctrl;
         int_stat <= next_int_stat;
         int_mask <= next_int_mask;
         clk_div <= next_clk_div;
         sample <= next_sample;
         RD_DATA <= next_rd_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Slice clocks, gating and status outputs.
   logic [15:0] div_cnt, next_div_cnt;
   logic next_rx_clk, next_tx_clk, next_rx_gate, next_tx_gate, next_irq;
   logic src_pll;
   logic [6:0] next_slice_enable;

   // The reference source serves receive slices only, so transmit stays off.
   assign src_pll = ctrl[NSC_CTRL_SRC_BIT] == NSC_SRC_PLL;

   always_comb begin
      next_div_cnt = div_cnt;
      next_rx_clk = RX_CLK;
      // A reference source parks the transmit clock low at once.
      next_tx_clk = src_pll ? TX_CLK : 1'b0;
      if (!cal_dly) begin
         next_div_cnt = 16'h0000;
         next_rx_clk = 1'b0;
         next_tx_clk = 1'b0;
      end else if (master_tick) begin
         // A divider of zero acts as one instead of wrapping to the maximum.
         if (clk_div == 16'h0000 || div_cnt >= clk_div - 16'h0001) begin
            next_div_cnt = 16'h0000;
            next_rx_clk = ~RX_CLK;
            next_tx_clk = src_pll ? ~TX_CLK : 1'b0;
         end else begin
            next_div_cnt = div_cnt + 16'h0001;
         end
      end
      next_rx_gate = ctrl[NSC_CTRL_RXG_BIT] & cal_dly;
      next_tx_gate = ctrl[NSC_CTRL_TXG_BIT] & cal_dly & src_pll;
      next_slice_enable = 7'h00;
      if (cal_dly) begin
         next_slice_enable = ctrl[NSC_CTRL_UPPER_BIT] ?
                             NSC_SLICES_UPPER : NSC_SLICES_LOWER;
      end
      next_irq = |(int_stat & int_mask);
   end

   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         div_cnt <= 16'h0000;
         RX_CLK <= 1'b0;
         TX_CLK <= 1'b0;
         RX_GATE <= 1'b0;
         TX_GATE <= 1'b0;
         SLICE_ENABLE <= 7'h00;
         DELAY_READY <= 1'b0;
         VT_READY <= 1'b0;
         IRQ <= 1'b0;
      end else if (CE) begin
         div_cnt <= next_div_cnt;
         RX_CLK <= next_rx_clk;
         TX_CLK <= next_tx_clk;
         RX_GATE <= next_rx_gate;
         TX_GATE <= next_tx_gate;
         SLICE_ENABLE <= next_slice_enable;
         DELAY_READY <= cal_dly;
         VT_READY <= cal_vt;
         IRQ <= next_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RESET_N);

   a_read_data: assert property (CE && rd_hit |=>
      RD_DATA == $past(rd_value))
      else $error("read data differs from addressed register");
   a_read_idle_zero: assert property (CE && !rd_hit |=>
      RD_DATA == 16'h0000)
      else $error("read data not zero outside a selected read");
   a_write_generic: assert property (CE && wr_hit &&
      is_generic(ADDR) |=> mem[$past(ADDR)] == $past(WR_DATA))
      else $error("generic register write lost");
   a_unsel_no_write: assert property (CE && WR_EN && !NIBBLE_SEL |=>
      ctrl == $past(ctrl) && clk_div == $past(clk_div))
      else $error("write taken while nibble not selected");
   a_dly_mirror: assert property (CE |=>
      DELAY_READY == $past(cal_dly))
      else $error("delay ready output does not mirror status");
   a_lower_slices: assert property (CE && !ctrl[NSC_CTRL_UPPER_BIT] |=>
      !SLICE_ENABLE[6])
      else $error("seventh slice enabled in a lower nibble");
   a_ref_no_tx: assert property (CE && !src_pll |=> !TX_GATE)
      else $error("transmit gating on with reference source");
   a_serial_sample: assert property (CE && master_tick &&
      ctrl[NSC_CTRL_SERIAL_BIT] |=> sample[7:0] == $past(sync2[9:2]))
      else $error("serial sample not captured on master tick");
   a_int_set_wins: assert property (CE && events[NSC_INT_DLY_BIT] |=>
      int_stat[NSC_INT_DLY_BIT])
      else $error("interrupt event lost against a clear");
   a_irq_level: assert property (CE |=>
      IRQ == |($past(int_stat) & $past(int_mask)))
      else $error("interrupt output does not follow masked status");
   a_slice_before_dly: assert property (CE && !cal_dly |=>
      SLICE_ENABLE == 7'h00)
      else $error("slices enabled before delay ready");
   a_upper_slices: assert property (CE && cal_dly &&
      ctrl[NSC_CTRL_UPPER_BIT] |=> SLICE_ENABLE == NSC_SLICES_UPPER)
      else $error("upper nibble does not enable seven slices");
   a_gate_needs_dly: assert property (CE && !cal_dly |=>
      !RX_GATE && !TX_GATE)
      else $error("gating active before delay ready");
   a_ref_no_txclk: assert property (CE && !src_pll |=> !TX_CLK)
      else $error("transmit clock running with reference source");
   a_clk_hold: assert property (CE && cal_dly && !master_tick |=>
      $stable(RX_CLK))
      else $error("receive clock moved without a master tick");
   a_freeze_hold: assert property (!CE |=>
      $stable(RX_CLK) && $stable(TX_CLK) && $stable(ctrl))
      else $error("state moved while the clock enable was low");
   a_ctrl_write: assert property (CE && wr_hit &&
      ADDR == NSC_OFS_CTRL |=> ctrl == $past(WR_DATA))
      else $error("control register write lost");
   a_vt_mirror: assert property (CE |=>
      VT_READY == $past(cal_vt))
      else $error("vt ready output does not mirror status");
   a_int_clear: assert property (CE && wr_hit &&
      ADDR == NSC_OFS_INT_STAT && WR_DATA[NSC_INT_DLY_BIT] &&
      !events[NSC_INT_DLY_BIT] |=> !int_stat[NSC_INT_DLY_BIT])
      else $error("interrupt status bit not cleared by a one");

   c_delay_ready: cover property ($rose(DELAY_READY));
   c_vt_ready: cover property ($rose(VT_READY));
   c_status_read: cover property (rd_hit && ADDR == NSC_OFS_STATUS);
   c_irq: cover property ($rose(IRQ));
endmodule : nsc_top
`default_nettype wire

// *** src/nsc_pkg.sv ***
// Constants, register map and types shared by the nibble slice controller.
package nsc_pkg;
   localparam int unsigned NSC_ADDR_W = 6;
   localparam int unsigned NSC_DATA_W = 16;
   localparam int unsigned NSC_REG_COUNT = 64;
   localparam int unsigned NSC_SLICE_MAX = 7;
   localparam int unsigned NSC_SYNC_W = 10;

   // Register offsets inside the 64-entry map.
   localparam logic [5:0] NSC_OFS_CTRL = 6'h00;
   localparam logic [5:0] NSC_OFS_STATUS = 6'h01;
   localparam logic [5:0] NSC_OFS_INT_STAT = 6'h02;
   localparam logic [5:0] NSC_OFS_INT_MASK = 6'h03;
   localparam logic [5:0] NSC_OFS_CLK_DIV = 6'h04;
   localparam logic [5:0] NSC_OFS_SAMPLE = 6'h05;

   // Control register fields.
   localparam int unsigned NSC_CTRL_SRC_BIT = 0;
   localparam int unsigned NSC_CTRL_SERIAL_BIT = 1;
   localparam int unsigned NSC_CTRL_RXG_BIT = 2;
   localparam int unsigned NSC_CTRL_TXG_BIT = 3;
   localparam int unsigned NSC_CTRL_UPPER_BIT = 4;
   localparam int unsigned NSC_CTRL_CAL_EN_BIT = 5;
   localparam logic [15:0] NSC_CTRL_RESET = 16'h0030;
   localparam logic NSC_SRC_PLL = 1'h0;
   localparam logic NSC_SRC_REF = 1'h1;

   // Status register fields.
   localparam int unsigned NSC_ST_DLY_BIT = 0;
   localparam int unsigned NSC_ST_VT_BIT = 1;
   localparam int unsigned NSC_ST_BUSY_BIT = 2;

   // Interrupt status and mask fields.
   localparam int unsigned NSC_INT_W = 3;
   localparam int unsigned NSC_INT_DLY_BIT = 0;
   localparam int unsigned NSC_INT_VT_BIT = 1;
   localparam int unsigned NSC_INT_LOST_BIT = 2;
   localparam logic [2:0] NSC_INT_RESET = 3'h0;

   localparam logic [15:0] NSC_CLK_DIV_RESET = 16'h0001;
   localparam logic [15:0] NSC_MEM_RESET = 16'h0000;
   localparam logic [6:0] NSC_SLICES_UPPER = 7'h7f;
   localparam logic [6:0] NSC_SLICES_LOWER = 7'h3f;

   // Calibration lengths, counted in master clock ticks.
   localparam logic [15:0] NSC_CAL_FIXED_TICKS = 16'h0040;
   localparam logic [15:0] NSC_CAL_VT_TICKS = 16'h0020;

   typedef enum logic [2:0] {
      NSC_CAL_IDLE,
      NSC_CAL_FIXED,
      NSC_CAL_WAIT_VT,
      NSC_CAL_VT_BASE,
      NSC_CAL_TRACK
   } nsc_cal_state_t;
endpackage : nsc_pkg

// *** src/nsc_cal.sv ***
// Self-calibration sequencer driven by master clock ticks.
`timescale 1ns/1ps
`default_nettype none
module nsc_cal
   import nsc_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic cal_en,
   input wire logic tick,
   input wire logic vt_en,
   output var logic delay_ready,
   output var logic vt_ready,
   output logic busy
);
   nsc_cal_state_t state, next_state;
   logic [15:0] cnt, next_cnt;
   logic next_delay_ready, next_vt_ready;

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_delay_ready = delay_ready;
      next_vt_ready = vt_ready;
      if (!cal_en) begin
         next_state = NSC_CAL_IDLE;
         next_cnt = 16'h0000;
         next_delay_ready = 1'b0;
         next_vt_ready = 1'b0;
      end else begin
         case (state)
            NSC_CAL_IDLE: begin
               next_state = NSC_CAL_FIXED;
            end
            NSC_CAL_FIXED: begin
               if (tick) begin
                  if (cnt == NSC_CAL_FIXED_TICKS - 16'h0001) begin
                     next_cnt = 16'h0000;
                     next_delay_ready = 1'b1;
                     next_state = NSC_CAL_WAIT_VT;
                  end else begin
                     next_cnt = cnt + 16'h0001;
                  end
               end
            end
            NSC_CAL_WAIT_VT: begin
               // Tracking starts only once the client raises the enable.
               if (vt_en) begin
                  next_cnt = 16'h0000;
                  next_state = NSC_CAL_VT_BASE;
               end
            end
            NSC_CAL_VT_BASE: begin
               if (!vt_en) begin
                  next_state = NSC_CAL_WAIT_VT;
               end else if (tick) begin
                  if (cnt == NSC_CAL_VT_TICKS - 16'h0001) begin
                     next_vt_ready = 1'b1;
                     next_state = NSC_CAL_TRACK;
                  end else begin
                     next_cnt = cnt + 16'h0001;
                  end
               end
            end
            NSC_CAL_TRACK: begin
               // Dropping the enable loses the baseline and forces a redo.
               if (!vt_en) begin
                  next_vt_ready = 1'b0;
                  next_state = NSC_CAL_WAIT_VT;
               end
            end
            default: begin
               next_state = NSC_CAL_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state <= NSC_CAL_IDLE;
         cnt <= 16'h0000;
         delay_ready <= 1'b0;
         vt_ready <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         cnt <= next_cnt;
         delay_ready <= next_delay_ready;
         vt_ready <= next_vt_ready;
      end
   end

   assign busy = (state == NSC_CAL_FIXED) || (state == NSC_CAL_VT_BASE);

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   a_fixed_count: assert property ($rose(delay_ready) |->
      $past(cnt) == NSC_CAL_FIXED_TICKS - 16'h0001 && $past(tick))
      else $error("delay ready rose before the fixed count ended");
   a_vt_needs_en: assert property (ce && !vt_en |=> !vt_ready)
      else $error("vt ready held without tracking enable");
   a_vt_after_dly: assert property (vt_ready |-> delay_ready)
      else $error("vt ready without delay ready");
endmodule : nsc_cal
`default_nettype wire

// *** dv/nsc_clk_src.sv ***
// Master clock source model for the PLL or the fabric reference input.
`timescale 1ns/1ps
`default_nettype none
module nsc_clk_src #(
   parameter int HALF_NS = 16
) (
   input wire logic enable,
   output var logic clk_out
);
   // The phase offset keeps the source unrelated to the system clock.
   initial begin
      clk_out = 1'b0;
      #3;
      forever begin
         #(HALF_NS);
         // A disabled source sits low, as an unused master input must.
         clk_out = enable ? ~clk_out : 1'b0;
      end
   end
endmodule : nsc_clk_src
`default_nettype wire

// *** dv/nsc_top_test.sv ***
// Self-checking testbench for the nibble slice controller.
`timescale 1ns/1ps
`default_nettype none
module nsc_top_test;
   import nsc_pkg::*;
   logic CLOCK = 1'b0;
   logic RESET_N = 1'b0;
   logic CE = 1'b1;
   logic pll_en = 1'b1;
   logic ref_en = 1'b0;
   logic VT_TRACK_EN = 1'b0;
   logic STROBE_IN = 1'b0;
   logic NIBBLE_SEL = 1'b1;
   logic WR_EN = 1'b0;
   logic RD_EN = 1'b0;
   logic [6:0] DATA_IN = 7'h00;
   logic [5:0] ADDR = 6'h00;
   logic [15:0] WR_DATA = 16'h0000;
   logic PLL_CLK, REF_CLK, DELAY_READY, VT_READY, RX_CLK, TX_CLK, RX_GATE;
   logic TX_GATE, IRQ;
   logic [15:0] RD_DATA;
   logic [6:0] SLICE_ENABLE;
   int errors = 0;
   int n_checks = 0;
   int cycles = 0;
   always #4 CLOCK = ~CLOCK;
   nsc_clk_src #(.HALF_NS(16)) pll (.enable(pll_en), .clk_out(PLL_CLK));
   nsc_clk_src #(.HALF_NS(20)) refsrc (.enable(ref_en), .clk_out(REF_CLK));
   nsc_top dut (.CLOCK(CLOCK), .RESET_N(RESET_N), .CE(CE),
      .PLL_CLK(PLL_CLK), .REF_CLK(REF_CLK), .VT_TRACK_EN(VT_TRACK_EN),
      .DATA_IN(DATA_IN), .STROBE_IN(STROBE_IN), .NIBBLE_SEL(NIBBLE_SEL),
      .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_EN(WR_EN), .RD_EN(RD_EN),
      .RD_DATA(RD_DATA), .DELAY_READY(DELAY_READY), .VT_READY(VT_READY),
      .RX_CLK(RX_CLK), .TX_CLK(TX_CLK), .RX_GATE(RX_GATE),
      .TX_GATE(TX_GATE), .SLICE_ENABLE(SLICE_ENABLE), .IRQ(IRQ));
   ////////////////////////////////////////////////////////////////////////
   task results;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : results
   // The whole run needs well under two thousand cycles.
   always @(posedge CLOCK) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         $display("ERROR %0t: run timed out", $time);
         results();
      end
   end
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge CLOCK);
      ADDR <= a;
      WR_DATA <= d;
      WR_EN <= 1'b1;
      @(posedge CLOCK);
      WR_EN <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe, so sample there.
   task rd(input logic [5:0] a, output logic [15:0] d);
      @(posedge CLOCK);
      ADDR <= a;
      RD_EN <= 1'b1;
      @(posedge CLOCK);
      RD_EN <= 1'b0;
      #1;
      d = RD_DATA;
   endtask : rd
   task rchk(input logic [5:0] a, input logic [15:0] exp);
      logic [15:0] d;
      rd(a, d);
      chk(d, exp);
   endtask : rchk
   task wait_cycles(input int n);
      repeat (n) @(posedge CLOCK);
      #1;
   endtask : wait_cycles
   ////////////////////////////////////////////////////////////////////////
   task t_reset;
      chk({15'h0, DELAY_READY}, 16'h0000);
      chk({9'h0, SLICE_ENABLE}, 16'h0000);
      rchk(NSC_OFS_CTRL, NSC_CTRL_RESET);
      rchk(NSC_OFS_CLK_DIV, NSC_CLK_DIV_RESET);
      rchk(NSC_OFS_INT_MASK, 16'h0000);
      rchk(6'h3f, NSC_MEM_RESET);
   endtask : t_reset
   task t_regs;
      wr(6'h06, 16'ha5a5);
      wr(6'h3f, 16'h5a5a);
      wr(NSC_OFS_INT_MASK, 16'h0007);
      rchk(6'h06, 16'ha5a5);
      rchk(6'h3f, 16'h5a5a);
      rchk(6'h07, 16'h0000);
      rchk(NSC_OFS_INT_MASK, 16'h0007);
   endtask : t_regs
   // An unselected controller must stay silent so the merged bus reads one.
   task t_merge;
      NIBBLE_SEL <= 1'b0;
      wr(6'h06, 16'hffff);
      rchk(6'h06, 16'h0000);
      NIBBLE_SEL <= 1'b1;
      rchk(6'h06, 16'ha5a5);
   endtask : t_merge
   task t_cal;
      logic [15:0] d;
      for (int i = 0; i < 1000 && DELAY_READY !== 1'b1; i++) wait_cycles(1);
      chk({15'h0, DELAY_READY}, 16'h0001);
      wait_cycles(3);
      chk({9'h0, SLICE_ENABLE}, {9'h0, NSC_SLICES_UPPER});
      chk({15'h0, IRQ}, 16'h0001);
      rd(NSC_OFS_STATUS, d);
      chk({15'h0, d[NSC_ST_DLY_BIT]}, 16'h0001);
      rchk(NSC_OFS_INT_STAT, 16'h0001);
      wr(NSC_OFS_INT_STAT, 16'h0001);
      wait_cycles(3);
      chk({15'h0, IRQ}, 16'h0000);
   endtask : t_cal
   task t_gate;
      logic prev;
      wr(NSC_OFS_CTRL, 16'h003c);
      wait_cycles(3);
      chk({14'h0, RX_GATE, TX_GATE}, 16'h0003);
      prev = RX_CLK;
      for (int i = 0; i < 40 && RX_CLK === prev; i++) wait_cycles(1);
      chk({15'h0, RX_CLK}, {15'h0, ~prev});
      chk({15'h0, TX_CLK}, {15'h0, ~prev});
      wr(NSC_OFS_CTRL, 16'h0024);
      wait_cycles(3);
      chk({9'h0, SLICE_ENABLE}, {9'h0, NSC_SLICES_LOWER});
      chk({14'h0, RX_GATE, TX_GATE}, 16'h0002);
   endtask : t_gate
   task t_serial;
      DATA_IN <= 7'h55;
      STROBE_IN <= 1'b1;
      wr(NSC_OFS_CTRL, 16'h0032);
      wait_cycles(30);
      rchk(NSC_OFS_SAMPLE, 16'h00d5);
      wr(NSC_OFS_SAMPLE, 16'h0000);
      rchk(NSC_OFS_SAMPLE, 16'h00d5);
   endtask : t_serial
   // Tracking is only requested once delay ready has been seen.
   task t_vt;
      VT_TRACK_EN <= 1'b1;
      for (int i = 0; i < 600 && VT_READY !== 1'b1; i++) wait_cycles(1);
      chk({15'h0, VT_READY}, 16'h0001);
      rchk(NSC_OFS_INT_STAT, 16'h0002);
      wr(NSC_OFS_INT_STAT, 16'h0002);
   endtask : t_vt
   // The reference source serves receive slices only, so transmit stays off.
   task t_ref;
      logic prev;
      wr(NSC_OFS_CTRL, 16'h0039);
      pll_en <= 1'b0;
      ref_en <= 1'b1;
      wait_cycles(3);
      chk({14'h0, TX_GATE, TX_CLK}, 16'h0000);
      prev = RX_CLK;
      for (int i = 0; i < 40 && RX_CLK === prev; i++) wait_cycles(1);
      chk({15'h0, RX_CLK}, {15'h0, ~prev});
      chk({15'h0, TX_CLK}, 16'h0000);
   endtask : t_ref
   // Dropping the tracking enable clears the tracking flag and raises an event.
   task t_lost;
      VT_TRACK_EN <= 1'b0;
      wait_cycles(3);
      chk({15'h0, VT_READY}, 16'h0000);
      chk({15'h0, IRQ}, 16'h0001);
      rchk(NSC_OFS_INT_STAT, 16'h0004);
      wr(NSC_OFS_INT_STAT, 16'h0004);
   endtask : t_lost
   // With the enable low nothing moves and a bus strobe is lost.
   task t_freeze;
      logic prev;
      CE <= 1'b0;
      wait_cycles(1);
      prev = RX_CLK;
      wait_cycles(40);
      chk({15'h0, RX_CLK}, {15'h0, prev});
      wr(6'h08, 16'h1234);
      CE <= 1'b1;
      rchk(6'h08, 16'h0000);
   endtask : t_freeze
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge CLOCK);
      RESET_N <= 1'b1;
      wait_cycles(1);
      t_reset();
      t_regs();
      t_merge();
      t_cal();
      t_vt();
      t_gate();
      t_serial();
      t_ref();
      t_lost();
      t_freeze();
      RESET_N <= 1'b0;
      wait_cycles(3);
      RESET_N <= 1'b1;
      wait_cycles(1);
      t_reset();
      results();
   end
endmodule : nsc_top_test
`default_nettype wire
